// [battery_alert_pkg.sv]
// Constants and types shared by the battery status, buzzer and state control logic.
// Operation
// - Replace lamp on when cycles reach end-of-life limit or capacity under end level.
// - Warn lamp on when cycles reach warning limit or capacity under warning level.
// - Good lamp on only while neither warn nor replace condition holds.
// - Charge lamp follows charging, discharge lamp follows discharging.
// - Full lamp on once a qualified full charge is detected.
// - Each beep lasts one second, each gap between beeps one second.
// - A configured beep count of zero silences that condition entirely.
// - One hour after a voltage alert, recheck and beep again if still present.
// - After the recheck, ignore that voltage condition until voltage is normal again.
// - Config bits 1:0 give zero to three beeps for runtime reaching empty.
// - Fields 3:2, 5:4, 7:6 give beeps for runtime reaching segment sums.
// - Fields 10:8 and 13:11 give zero to seven beeps for over/undervoltage.
// - Current at or over activation threshold enters active state, display on.
// - Current at or under idle threshold enters idle, display holds last value.
// - Idle longer than the sleep delay in seconds enters sleep, display off.
// - Measurement, time keeping and serial service keep running in every state.
// - Charge accumulation runs only in the active state.
// - Status lamps are shifted out to external latches whenever a status changes.
package battery_alert_pkg;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int BEEP_TIME_MS = 1000;
   localparam int SECOND_CYCLES = BEEP_TIME_MS * CLK_FREQ_MHZ * 1000;
   localparam int RECHECK_TIME_S = 3600;
   localparam logic [11:0] RECHECK_LAST = 12'(RECHECK_TIME_S - 1);
   localparam int EMPTY_LSB = 0;
   localparam int SEG0_LSB = 2;
   localparam int SEG1_LSB = 4;
   localparam int SEG2_LSB = 6;
   localparam int OV_LSB = 8;
   localparam int UV_LSB = 11;
   localparam int SHORT_W = 2;
   localparam int LONG_W = 3;
   localparam logic [15:0] BEEP_CFG_RESET = 16'h0000;
   localparam int SR_BITS = 6;
   localparam logic [2:0] SR_LAST = 3'h5;
   localparam int SR_FRAME_CYCLES = 12;
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b001,
      ST_IDLE = 3'b010,
      ST_SLEEP = 3'b100
   } op_state_t;
   typedef enum logic [2:0] {
      VW_ARMED = 3'b001,
      VW_WAIT = 3'b010,
      VW_DONE = 3'b100
   } volt_watch_t;
   typedef enum logic [2:0] {
      SR_IDLE = 3'b001,
      SR_SHIFT = 3'b010,
      SR_LATCH = 3'b100
   } shift_state_t;
   typedef enum logic [2:0] {
      BZ_IDLE = 3'b001,
      BZ_ON = 3'b010,
      BZ_GAP = 3'b100
   } beep_state_t;
endpackage

// [battery_status_alert_control.sv]
// Status lamps, buzzer alerts and operating-state control for the battery gauge.
`timescale 1ns/1ps
module battery_status_alert_control
   import battery_alert_pkg::*;
#(
   parameter int SEC_CYCLES = SECOND_CYCLES,
   parameter int COUNT_W = 16,
   parameter int CAP_W = 16,
   parameter int RUN_W = 16,
   parameter int VOLT_W = 16,
   parameter int CUR_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [COUNT_W-1:0] cycle_count_i,
   input wire logic [COUNT_W-1:0] eol_cycle_limit_i,
   input wire logic [COUNT_W-1:0] warn_cycle_limit_i,
   input wire logic [CAP_W-1:0] learned_full_capacity_i,
   input wire logic [CAP_W-1:0] eol_capacity_level_i,
   input wire logic [CAP_W-1:0] warn_capacity_level_i,
   input wire logic charging_i,
   input wire logic discharging_i,
   input wire logic full_detected_i,
   input wire logic [RUN_W-1:0] remaining_runtime_i,
   input wire logic [23:0] segment_time_allocation_i,
   input wire logic [VOLT_W-1:0] battery_voltage_i,
   input wire logic [VOLT_W-1:0] overvoltage_threshold_i,
   input wire logic [VOLT_W-1:0] undervoltage_threshold_i,
   input wire logic [CUR_W-1:0] current_magnitude_i,
   input wire logic [CUR_W-1:0] activation_current_threshold_i,
   input wire logic [CUR_W-1:0] idle_current_threshold_i,
   input wire logic [15:0] sleep_delay_seconds_i,
   input wire logic cfg_wr_i,
   input wire logic [15:0] cfg_wdata_i,
   output logic [15:0] cfg_rdata_o,
   output logic replace_o,
   output logic warn_o,
   output logic good_o,
   output logic charge_o,
   output logic discharge_o,
   output logic full_o,
   output logic sr_data_o,
   output logic sr_clk_o,
   output logic sr_latch_o,
   output logic buzzer_o,
   output logic [2:0] op_state_o,
   output logic display_on_o,
   output logic display_hold_o,
   output logic coulomb_count_en_o,
   output logic measure_en_o,
   output logic serial_en_o
);
   beep_if beep ();

   logic [15:0] buzzer_beep_config;
   logic replace_cond;
   logic warn_cond;
   logic [SR_BITS-1:0] status_vec;
   logic [SR_BITS-1:0] sent_vec;
   logic [SR_BITS-1:0] sr_shadow;
   shift_state_t sr_state;
   logic [2:0] sr_cnt;
   logic sr_phase;
   logic [31:0] sec_cnt;
   logic sec_tick;
   logic [RUN_W-1:0] cum0;
   logic [RUN_W-1:0] cum1;
   logic [RUN_W-1:0] cum2;
   logic [3:0] run_cond;
   logic [3:0] run_cond_q;
   logic [1:0] volt_cond;
   logic volt_normal;
   logic [1:0] volt_ev;
   logic [5:0] events;
   logic [5:0] pending;
   logic [5:0] grant;
   logic [2:0] sel;
   logic sel_valid;
   logic start_q;
   logic [2:0] start_count;
   op_state_t state;
   logic [15:0] idle_secs;

   // Pull the beep count of one alert source out of the configuration word.
   function automatic logic [2:0] field_count(input logic [15:0] cfg, input logic [2:0] src);
      logic [2:0] n;
      n = 3'h0;
      case (src)
         3'h0: n = {1'b0, cfg[EMPTY_LSB +: SHORT_W]};
         3'h1: n = {1'b0, cfg[SEG0_LSB +: SHORT_W]};
         3'h2: n = {1'b0, cfg[SEG1_LSB +: SHORT_W]};
         3'h3: n = {1'b0, cfg[SEG2_LSB +: SHORT_W]};
         3'h4: n = cfg[OV_LSB +: LONG_W];
         3'h5: n = cfg[UV_LSB +: LONG_W];
         default: n = 3'h0;
      endcase
      return n;
   endfunction

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buzzer_beep_config <= BEEP_CFG_RESET;
         cfg_rdata_o <= BEEP_CFG_RESET;
      end else begin
         if (cfg_wr_i) begin
            buzzer_beep_config <= cfg_wdata_i;
         end
         cfg_rdata_o <= buzzer_beep_config;
      end
   end

   assign replace_cond = (cycle_count_i >= eol_cycle_limit_i) ||
                         (learned_full_capacity_i < eol_capacity_level_i);
   assign warn_cond = (cycle_count_i >= warn_cycle_limit_i) ||
                      (learned_full_capacity_i < warn_capacity_level_i);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         replace_o <= 1'b0;
         warn_o <= 1'b0;
         good_o <= 1'b0;
         charge_o <= 1'b0;
         discharge_o <= 1'b0;
         full_o <= 1'b0;
      end else begin
         replace_o <= replace_cond;
         warn_o <= warn_cond;
         good_o <= !(replace_cond || warn_cond);
         charge_o <= charging_i;
         discharge_o <= discharging_i;
         full_o <= full_detected_i;
      end
   end

   assign status_vec = {replace_o, warn_o, good_o, charge_o, discharge_o, full_o};

   // A change that lands mid-frame is caught on the next idle cycle, so no update is lost.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sr_state <= SR_IDLE;
         sent_vec <= '0;
         sr_shadow <= '0;
         sr_cnt <= 3'h0;
         sr_phase <= 1'b0;
         sr_data_o <= 1'b0;
         sr_clk_o <= 1'b0;
         sr_latch_o <= 1'b0;
      end else begin
         case (sr_state)
            SR_IDLE: begin
               sr_latch_o <= 1'b0;
               if (status_vec != sent_vec) begin
                  sent_vec <= status_vec;
                  sr_shadow <= status_vec;
                  sr_cnt <= 3'h0;
                  sr_phase <= 1'b0;
                  sr_state <= SR_SHIFT;
               end
            end
            SR_SHIFT: begin
               sr_phase <= !sr_phase;
               if (!sr_phase) begin
                  sr_data_o <= sr_shadow[SR_BITS-1];
                  sr_clk_o <= 1'b0;
               end else begin
                  sr_clk_o <= 1'b1;
                  sr_shadow <= {sr_shadow[SR_BITS-2:0], 1'b0};
                  sr_cnt <= sr_cnt + 3'h1;
                  if (sr_cnt == SR_LAST) begin
                     sr_state <= SR_LATCH;
                  end
               end
            end
            SR_LATCH: begin
               sr_clk_o <= 1'b0;
               sr_latch_o <= 1'b1;
               sr_state <= SR_IDLE;
            end
            default: begin
               sr_state <= SR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sec_cnt <= 32'h00000000;
         sec_tick <= 1'b0;
      end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
         sec_cnt <= 32'h00000000;
         sec_tick <= 1'b1;
      end else begin
         sec_cnt <= sec_cnt + 32'h00000001;
         sec_tick <= 1'b0;
      end
   end

   assign cum0 = RUN_W'(segment_time_allocation_i[7:0]);
   assign cum1 = cum0 + RUN_W'(segment_time_allocation_i[15:8]);
   assign cum2 = cum1 + RUN_W'(segment_time_allocation_i[23:16]);
   assign run_cond[0] = discharging_i && (remaining_runtime_i == '0);
   assign run_cond[1] = discharging_i && (remaining_runtime_i == cum0);
   assign run_cond[2] = discharging_i && (remaining_runtime_i == cum1);
   assign run_cond[3] = discharging_i && (remaining_runtime_i == cum2);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_cond_q <= 4'h0;
      end else begin
         run_cond_q <= run_cond;
      end
   end

   assign volt_cond[0] = battery_voltage_i > overvoltage_threshold_i;
   assign volt_cond[1] = battery_voltage_i < undervoltage_threshold_i;
   assign volt_normal = !volt_cond[0] && !volt_cond[1];

   for (genvar g = 0; g < 2; g++) begin : gen_volt
      volt_watch_t vstate;
      logic [11:0] hour_secs;
      assign volt_ev[g] = (vstate == VW_ARMED && volt_cond[g]) ||
                          (vstate == VW_WAIT && sec_tick && hour_secs == RECHECK_LAST &&
                           volt_cond[g]);
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            vstate <= VW_ARMED;
            hour_secs <= 12'h000;
         end else begin
            case (vstate)
               VW_ARMED: begin
                  if (volt_cond[g]) begin
                     vstate <= VW_WAIT;
                     hour_secs <= 12'h000;
                  end
               end
               VW_WAIT: begin
                  if (sec_tick) begin
                     hour_secs <= hour_secs + 12'h001;
                     if (hour_secs == RECHECK_LAST) begin
                        vstate <= VW_DONE;
                     end
                  end
               end
               VW_DONE: begin
                  if (volt_normal) begin
                     vstate <= VW_ARMED;
                  end
               end
               default: begin
                  vstate <= VW_ARMED;
               end
            endcase
         end
      end
   end

   assign events = {volt_ev, run_cond & ~run_cond_q};

   always_comb begin
      sel = 3'h0;
      sel_valid = 1'b0;
      grant = 6'h00;
      for (int i = 5; i >= 0; i--) begin
         if (pending[i]) begin
            sel = 3'(i);
            sel_valid = 1'b1;
         end
      end
      if (sel_valid && !beep.busy && !start_q) begin
         grant[sel] = 1'b1;
      end
   end

   // A new event on a source beats its own grant in the same cycle.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pending <= 6'h00;
         start_q <= 1'b0;
         start_count <= 3'h0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (events[i] && field_count(buzzer_beep_config, 3'(i)) != 3'h0) begin
               pending[i] <= 1'b1;
            end else if (grant[i]) begin
               pending[i] <= 1'b0;
            end
         end
         start_q <= |grant;
         start_count <= field_count(buzzer_beep_config, sel);
      end
   end

   assign beep.start = start_q;
   assign beep.count = start_count;

   beep_sequencer #(
      .SEC_CYCLES(SEC_CYCLES)
   ) i_beep_sequencer (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .bus(beep.seq),
      .buzzer_o(buzzer_o)
   );

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_SLEEP;
         idle_secs <= 16'h0000;
      end else if (current_magnitude_i >= activation_current_threshold_i) begin
         state <= ST_ACTIVE;
      end else begin
         case (state)
            ST_ACTIVE: begin
               if (current_magnitude_i <= idle_current_threshold_i) begin
                  state <= ST_IDLE;
                  idle_secs <= 16'h0000;
               end
            end
            ST_IDLE: begin
               if (sec_tick) begin
                  if (idle_secs >= sleep_delay_seconds_i) begin
                     state <= ST_SLEEP;
                  end else begin
                     idle_secs <= idle_secs + 16'h0001;
                  end
               end
            end
            ST_SLEEP: begin
               state <= ST_SLEEP;
            end
            default: begin
               state <= ST_SLEEP;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_state_o <= ST_SLEEP;
         display_on_o <= 1'b0;
         display_hold_o <= 1'b0;
         coulomb_count_en_o <= 1'b0;
         measure_en_o <= 1'b0;
         serial_en_o <= 1'b0;
      end else begin
         op_state_o <= state;
         display_on_o <= (state != ST_SLEEP);
         display_hold_o <= (state == ST_IDLE);
         coulomb_count_en_o <= (state == ST_ACTIVE);
         measure_en_o <= 1'b1;
         serial_en_o <= 1'b1;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_replace;
      replace_cond |=> replace_o;
   endproperty
   a_replace: assert property (p_replace) else $error("Replace lamp missed.");

   property p_warn;
      warn_cond |=> warn_o;
   endproperty
   a_warn: assert property (p_warn) else $error("Warn lamp missed.");

   property p_good;
      good_o |-> (!replace_o && !warn_o);
   endproperty
   a_good: assert property (p_good) else $error("Good lamp with health fault.");

   property p_mode;
      ##1 (charge_o == $past(charging_i)) && (discharge_o == $past(discharging_i));
   endproperty
   a_mode: assert property (p_mode) else $error("Mode lamps wrong.");

   property p_full;
      full_detected_i |=> full_o;
   endproperty
   a_full: assert property (p_full) else $error("Full lamp missed.");

   sequence s_frame;
      sr_state == SR_SHIFT ##11 sr_state == SR_SHIFT ##1 sr_state == SR_LATCH ##1 sr_latch_o;
   endsequence
   property p_shift;
      (sr_state == SR_IDLE && status_vec != sent_vec) |=> s_frame;
   endproperty
   a_shift: assert property (p_shift) else $error("Lamp frame not sent.");

   property p_zero;
      (events[1] && buzzer_beep_config[SEG0_LSB +: SHORT_W] == 2'h0 && !pending[1])
         |=> !pending[1];
   endproperty
   a_zero: assert property (p_zero) else $error("Zero count queued a beep.");

   property p_queue;
      start_q |-> !$past(beep.busy);
   endproperty
   a_queue: assert property (p_queue) else $error("Start while sounding.");

   property p_wake;
      (state == ST_SLEEP && current_magnitude_i >= activation_current_threshold_i)
         |=> state == ST_ACTIVE ##1 display_on_o;
   endproperty
   a_wake: assert property (p_wake) else $error("No wake from sleep.");

   property p_coulomb;
      ##1 coulomb_count_en_o == ($past(state) == ST_ACTIVE);
   endproperty
   a_coulomb: assert property (p_coulomb) else $error("Counting outside active.");

   property p_sleep_off;
      (state == ST_SLEEP) |=> !display_on_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("Display on in sleep.");
endmodule

// [battery_status_alert_control_bench.sv]
// Self-checking bench for the battery status, buzzer and state control block.
`timescale 1ns/1ps
module battery_status_alert_control_bench;
   localparam int SEC = 20;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] cyc = 16'h0005, cap = 16'h0064, rtt = 16'h0064, volt = 16'h0080;
   logic [15:0] cur = 16'h0000, sleep_s = 16'h0002, wdata = 16'h0000;
   logic [15:0] ovt = 16'h0100, uvt = 16'h0040, act = 16'h0064, idl = 16'h000A;
   logic chg = 1'b0, dis = 1'b0, full = 1'b0, wr = 1'b0;
   logic [15:0] rdata;
   logic [2:0] op;
   logic [5:0] shown;
   logic rep, wrn, good, chg_l, dis_l, full_l, sd, sc, sl, buz, buzzing;
   logic disp, hold, ccen, meas, ser;
   int fails = 0;
   int n_compared = 0;
   int high, rises;
   always #2.5 clk = ~clk;
   battery_status_alert_control #(.SEC_CYCLES(SEC)) i_battery_status_alert_control (
      .core_clk_i(clk), .rst_b_i(rst_b), .cycle_count_i(cyc),
      .eol_cycle_limit_i(16'h000A), .warn_cycle_limit_i(16'h0008),
      .learned_full_capacity_i(cap), .eol_capacity_level_i(16'h0032),
      .warn_capacity_level_i(16'h0050), .charging_i(chg), .discharging_i(dis),
      .full_detected_i(full), .remaining_runtime_i(rtt),
      .segment_time_allocation_i(24'h140804), .battery_voltage_i(volt),
      .overvoltage_threshold_i(ovt), .undervoltage_threshold_i(uvt),
      .current_magnitude_i(cur), .activation_current_threshold_i(act),
      .idle_current_threshold_i(idl), .sleep_delay_seconds_i(sleep_s),
      .cfg_wr_i(wr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .replace_o(rep),
      .warn_o(wrn), .good_o(good), .charge_o(chg_l), .discharge_o(dis_l),
      .full_o(full_l), .sr_data_o(sd), .sr_clk_o(sc), .sr_latch_o(sl), .buzzer_o(buz),
      .op_state_o(op), .display_on_o(disp), .display_hold_o(hold),
      .coulomb_count_en_o(ccen), .measure_en_o(meas), .serial_en_o(ser));
   lamp_latch_model i_lamp_latch_model (.sr_data_i(sd), .sr_clk_i(sc), .sr_latch_i(sl),
      .buzzer_i(buz), .shown_o(shown), .buzzing_o(buzzing));
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Outputs are looked at on the falling edge, well clear of the launching edge.
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg_write(input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic lamps(input logic [15:0] c, input logic [15:0] k, input logic ch,
                        input logic f, input logic [5:0] exp);
      @(posedge clk);
      cyc <= c;
      cap <= k;
      chg <= ch;
      dis <= ~ch;
      full <= f;
      wait_n(2);
      chk("lamps", {10'h000, exp}, {10'h000, rep, wrn, good, chg_l, dis_l, full_l});
      wait_n(30);
      chk("latched lamps", {10'h000, exp}, {10'h000, shown});
   endtask
   task automatic listen(input int n);
      logic last;
      high = 0;
      rises = 0;
      last = buzzing;
      repeat (n) begin
         @(negedge clk);
         if (buzzing === 1'b1) high++;
         if (buzzing === 1'b1 && last !== 1'b1) rises++;
         last = buzzing;
      end
   endtask
   initial begin
      wait_n(1);
      chk("state in reset", 16'h0004, {13'h0000, op});
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wait_n(2);
      chk("measure and serial", 16'h0003, {14'h0000, meas, ser});
      cfg_write(16'hC102);
      wait_n(2);
      chk("beep config", 16'hC102, rdata);
      lamps(16'h0005, 16'h0064, 1'b0, 1'b0, 6'h0A);
      lamps(16'h0008, 16'h0064, 1'b0, 1'b0, 6'h12);
      lamps(16'h0005, 16'h004F, 1'b0, 1'b0, 6'h12);
      lamps(16'h0005, 16'h0032, 1'b0, 1'b0, 6'h12);
      lamps(16'h000A, 16'h0064, 1'b1, 1'b1, 6'h35);
      lamps(16'h0005, 16'h0031, 1'b0, 1'b0, 6'h32);
      lamps(16'h0005, 16'h0064, 1'b0, 1'b0, 6'h0A);
      @(posedge clk);
      cur <= 16'h0064;
      wait_n(3);
      chk("active", 16'h000D, {10'h000, op, disp, hold, ccen});
      @(posedge clk);
      cur <= 16'h000A;
      wait_n(3);
      chk("idle", 16'h0016, {10'h000, op, disp, hold, ccen});
      wait_n(12);
      chk("still idle", 16'h0002, {13'h0000, op});
      wait_n(60);
      chk("sleep", 16'h0020, {10'h000, op, disp, hold, ccen});
      @(posedge clk);
      cur <= 16'h00C8;
      wait_n(3);
      chk("wake", 16'h000D, {10'h000, op, disp, hold, ccen});
      @(posedge clk);
      rtt <= 16'h0005;
      wait_n(2);
      @(posedge clk);
      rtt <= 16'h0004;
      listen(60);
      chk("silent beeps", 16'h0000, 16'(rises));
      @(posedge clk);
      rtt <= 16'h0001;
      wait_n(2);
      // Empty and overvoltage fire together, so the second sequence must queue.
      @(posedge clk);
      rtt <= 16'h0000;
      volt <= 16'h0101;
      listen(220);
      chk("beep count", 16'h0003, 16'(rises));
      chk("beep time", 16'(3 * SEC), 16'(high));
      give_verdict();
   end
   initial begin
      #100000;
      fails++;
      give_verdict();
   end
endmodule

// [beep_if.sv]
// Carrier between the alert controller and the beep sequencer.
`timescale 1ns/1ps
interface beep_if;
   logic start;
   logic [2:0] count;
   logic busy;
   modport ctl (output start, output count, input busy);
   modport seq (input start, input count, output busy);
endinterface

// [beep_sequencer.sv]
// Beep sequencer: sounds a number of one-second beeps separated by one-second gaps.
`timescale 1ns/1ps
module beep_sequencer
   import battery_alert_pkg::*;
#(
   parameter int SEC_CYCLES = SECOND_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   beep_if.seq bus,
   output logic buzzer_o
);
   beep_state_t state;
   logic [31:0] cnt;
   logic [2:0] left;
   logic last;
   logic [31:0] on_len;

   assign last = (cnt == 32'(SEC_CYCLES - 1));
   // Busy also covers the final gap, so a queued sequence never merges with this one.
   assign bus.busy = (state != BZ_IDLE);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= BZ_IDLE;
         cnt <= 32'h00000000;
         left <= 3'h0;
         buzzer_o <= 1'b0;
      end else begin
         case (state)
            BZ_IDLE: begin
               if (bus.start && bus.count != 3'h0) begin
                  state <= BZ_ON;
                  left <= bus.count;
                  cnt <= 32'h00000000;
                  buzzer_o <= 1'b1;
               end
            end
            BZ_ON: begin
               if (last) begin
                  state <= BZ_GAP;
                  left <= left - 3'h1;
                  cnt <= 32'h00000000;
                  buzzer_o <= 1'b0;
               end else begin
                  cnt <= cnt + 32'h00000001;
               end
            end
            BZ_GAP: begin
               if (last) begin
                  cnt <= 32'h00000000;
                  if (left == 3'h0) begin
                     state <= BZ_IDLE;
                  end else begin
                     state <= BZ_ON;
                     buzzer_o <= 1'b1;
                  end
               end else begin
                  cnt <= cnt + 32'h00000001;
               end
            end
            default: begin
               state <= BZ_IDLE;
               buzzer_o <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         on_len <= 32'h00000000;
      end else if (buzzer_o) begin
         on_len <= on_len + 32'h00000001;
      end else begin
         on_len <= 32'h00000000;
      end
   end

   property p_beep_len;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(buzzer_o) |-> ($past(on_len) == 32'(SEC_CYCLES - 1));
   endproperty
   a_beep_len: assert property (p_beep_len) else $error("Beep length is not one second.");

   property p_zero_silent;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == BZ_IDLE && bus.start && bus.count == 3'h0) |=> (!buzzer_o && state == BZ_IDLE);
   endproperty
   a_zero_silent: assert property (p_zero_silent) else $error("Zero count made a sound.");
endmodule

// [lamp_latch_model.sv]
// Model of the external lamp shift registers and buzzer driver.
`timescale 1ns/1ps
module lamp_latch_model (
   input wire logic sr_data_i,
   input wire logic sr_clk_i,
   input wire logic sr_latch_i,
   input wire logic buzzer_i,
   output logic [5:0] shown_o,
   output logic buzzing_o
);
   logic [5:0] shift = 6'h00;
   initial shown_o = 6'h00;
   // The first bit shifted in ends up on top, as a real register chain does.
   always @(posedge sr_clk_i) begin
      shift <= {shift[4:0], sr_data_i};
   end
   // Lamps change only at the latch pulse, so a half-shifted frame never shows.
   always @(posedge sr_latch_i) begin
      shown_o <= shift;
   end
   assign buzzing_o = buzzer_i;
endmodule
